// >>> design/stored_config_diag_addr_regs.v
/*
 Stored configuration registers: upper-channel diagnostics
 enables, regulator voltage select, exponential dimming enable,
 stored bus address and the address-source bit, behind an
 Avalon-MM slave with waitrequest.
 Assumes a master that holds its request until waitrequest is low.
 Only byte lane 0 carries data; the other lanes are ignored.
 Apart from the bus address, the stored bits are not copied into any active register here;
 that copy belongs to the logic around this bank.
*/
// Behaviour
// - Bits 3..0 of the first register enable diagnostics for channels 11..8, one enables, each resets to one.
// - Bit 6 of the second register picks the regulator voltage, zero for 5.0 V and one for 4.4 V, reset zero.
// - Bit 4 of the second register turns exponential dimming on when one, reset zero.
// - Bits 3..0 of the second register hold the stored bus address, code n meaning address n.
// - The stored address resets to zero, or to eight in the lettered variant.
// - The bus address comes from the strap pins when the address-source bit is zero, else from the stored field.
`timescale 1ns/1ps
`include "cfg_regs_defines.vh"
module stored_config_diag_addr_regs #(
   parameter ALT_VARIANT = 0
) (
   input wire clk,
   input wire rst,
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire address_strap_pin_2,
   input wire address_strap_pin_1,
   input wire address_strap_pin_0,
   output reg stored_diag_on_ch_eleven,
   output reg stored_diag_on_ch_ten,
   output reg stored_diag_on_ch_nine,
   output reg stored_diag_on_ch_eight,
   output reg stored_regulator_voltage_sel,
   output reg stored_exponential_dimming_on,
   output reg [3:0] stored_bus_address,
   output reg address_source_select,
   output wire [3:0] active_bus_address
);

   // Stored copies of the three bytes, reserved bits held at zero
   reg [7:0] diag_reg;
   reg [7:0] cfg_reg;
   reg [7:0] src_reg;
   // High in the cycle after a request is taken
   reg served;
   // Request terms, decode and the byte a write would store
   wire req;
   wire wr_go;
   wire rd_go;
   wire hit_diag;
   wire hit_cfg;
   wire hit_src;
   wire [7:0] wbyte;
   wire [3:0] addr_reset_field;
   wire [7:0] addr_reset;

   // Writable bits of each offset; everything else is reserved
   function [7:0] write_mask;
      input [7:0] offset;
      begin
         case (offset)
            `DIAG_REG_OFFSET: write_mask = `DIAG_BITS_MASK;
            `CFG_REG_OFFSET: write_mask = `CFG_BITS_MASK;
            `ADDR_SRC_REG_OFFSET: write_mask = `ADDR_SRC_MASK;
            default: write_mask = 8'h00;
         endcase
      end
   endfunction

   // Keeps only the writable bits of a byte
   function [7:0] merge_byte;
      input [7:0] data;
      input [7:0] mask;
      begin
         merge_byte = data & mask;
      end
   endfunction

   // Compares the bus offset with one mapped byte
   function hits;
      input [7:0] offset;
      input [7:0] target;
      begin
         hits = (offset == target);
      end
   endfunction

   // A request is taken once; the write lands when the master
   // sees waitrequest low, never twice for one held request
   assign req = (avs_read | avs_write) & ~served;
   assign wr_go = avs_write & served & avs_byteenable[0];
   assign rd_go = req & avs_read;

   // One decode line per mapped byte
   assign hit_diag = hits(avs_address, `DIAG_REG_OFFSET);
   assign hit_cfg = hits(avs_address, `CFG_REG_OFFSET);
   assign hit_src = hits(avs_address, `ADDR_SRC_REG_OFFSET);

   // Write byte with reserved bits cleared
   assign wbyte = merge_byte(avs_writedata[7:0], write_mask(avs_address));

   // Only the stored address reset differs between variants
   assign addr_reset_field = ALT_VARIANT ? `STORED_ADDR_RESET_ALT
      : `STORED_ADDR_RESET;
   assign addr_reset = {4'h0, addr_reset_field};

   // One wait cycle, answer on the second edge of a request
   always @(posedge clk) begin
      if (rst) begin
         served <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else begin
         served <= req;
         avs_waitrequest <= ~req;
      end
   end

   // Diagnostics enables; a write without lane 0 is answered, dropped
   always @(posedge clk) begin
      if (rst) begin
         diag_reg <= `DIAG_REG_RESET;
      end else if (wr_go & hit_diag) begin
         diag_reg <= wbyte;
      end
   end

   // Regulator select, dimming enable and stored address
   always @(posedge clk) begin
      if (rst) begin
         cfg_reg <= `CFG_REG_RESET | addr_reset;
      end else if (wr_go & hit_cfg) begin
         cfg_reg <= wbyte;
      end
   end

   // Address-source byte, only its one bit is kept
   always @(posedge clk) begin
      if (rst) begin
         src_reg <= 8'h00;
      end else if (wr_go & hit_src) begin
         src_reg <= wbyte;
      end
   end

   // Read data loaded when the request is taken, so it stands at
   // the edge where the master sees waitrequest low
   always @(posedge clk) begin
      if (rst) begin
         avs_readdata <= `UNMAPPED_READ;
      end else if (rd_go) begin
         if (hit_diag) begin
            avs_readdata <= {24'h0, diag_reg};
         end else if (hit_cfg) begin
            avs_readdata <= {24'h0, cfg_reg};
         end else if (hit_src) begin
            avs_readdata <= {24'h0, src_reg};
         end else begin
            // Unmapped offsets read zero rather than erroring
            avs_readdata <= `UNMAPPED_READ;
         end
      end
   end

   // Diagnostics outputs, one edge behind the stored bits
   always @(posedge clk) begin
      if (rst) begin
         {stored_diag_on_ch_eleven, stored_diag_on_ch_ten,
            stored_diag_on_ch_nine, stored_diag_on_ch_eight} <= 4'hf;
      end else begin
         {stored_diag_on_ch_eleven, stored_diag_on_ch_ten,
            stored_diag_on_ch_nine, stored_diag_on_ch_eight}
            <= diag_reg[3:0];
      end
   end

   // Regulator, dimming and address outputs
   always @(posedge clk) begin
      if (rst) begin
         stored_regulator_voltage_sel <= 1'b0;
         stored_exponential_dimming_on <= 1'b0;
         stored_bus_address <= addr_reset_field;
      end else begin
         stored_regulator_voltage_sel <= cfg_reg[`REG_VOLT_BIT];
         stored_exponential_dimming_on <= cfg_reg[`EXP_DIM_BIT];
         stored_bus_address <= cfg_reg[3:0];
      end
   end

   // Address-source output
   always @(posedge clk) begin
      if (rst) begin
         address_source_select <= 1'b0;
      end else begin
         address_source_select <= src_reg[`ADDR_SRC_BIT];
      end
   end

   // Uses the stored bits directly to save a cycle of lag
   bus_address_select u_addr_sel (
      .clk(clk),
      .rst(rst),
      .address_source_select(src_reg[`ADDR_SRC_BIT]),
      .stored_bus_address(cfg_reg[3:0]),
      .address_strap_pin_2(address_strap_pin_2),
      .address_strap_pin_1(address_strap_pin_1),
      .address_strap_pin_0(address_strap_pin_0),
      .active_bus_address(active_bus_address)
   );
endmodule

// >>> design/cfg_regs_defines.vh
/*
 Offsets, field positions, reset values and the write masks
 of the stored configuration register bank.
 Assumes inclusion by bare name from design files.
*/
`ifndef CFG_REGS_DEFINES_VH
`define CFG_REGS_DEFINES_VH

`define DIAG_REG_OFFSET 8'hc5
`define CFG_REG_OFFSET 8'hc6
`define ADDR_SRC_REG_OFFSET 8'hc7
`define DIAG_REG_RESET 8'h0f
`define CFG_REG_RESET 8'h00
`define DIAG_BITS_MASK 8'h0f
`define CFG_BITS_MASK 8'h5f
`define ADDR_SRC_MASK 8'h08
`define REG_VOLT_BIT 6
`define EXP_DIM_BIT 4
`define ADDR_SRC_BIT 3
`define STORED_ADDR_RESET 4'h0
`define STORED_ADDR_RESET_ALT 4'h8
`define UNMAPPED_READ 32'h00000000

`endif

// >>> design/bus_address_select.v
/*
 Picks the bus address the device answers to: the strap pins or
 the stored address field.
 Assumes strap pins are steady and synchronous to clk.
*/
`timescale 1ns/1ps
module bus_address_select (
   input wire clk,
   input wire rst,
   input wire address_source_select,
   input wire [3:0] stored_bus_address,
   input wire address_strap_pin_2,
   input wire address_strap_pin_1,
   input wire address_strap_pin_0,
   output reg [3:0] active_bus_address
);

   // Strap address has three pins, so its top bit is zero
   always @(posedge clk) begin
      if (rst) begin
         active_bus_address <= 4'h0;
      end else if (address_source_select) begin
         active_bus_address <= stored_bus_address;
      end else begin
         active_bus_address <= {1'b0, address_strap_pin_2,
            address_strap_pin_1, address_strap_pin_0};
      end
   end
endmodule

// >>> sim/host_master.sv
/* Avalon-MM host model, one bus cycle per call.
 Assumes the bench clock; a wait gives up after 21 edges. */
`timescale 1ns/1ps
module host_master (
   input wire clk,
   input wire avs_waitrequest,
   input wire [31:0] avs_readdata,
   output reg [7:0] avs_address = 8'h00,
   output reg avs_read = 1'b0,
   output reg avs_write = 1'b0,
   output reg [31:0] avs_writedata = 32'h0,
   output reg [3:0] avs_byteenable = 4'h0
);
   reg to = 1'b0;
   // Hold until waitrequest low, then scramble lines no longer valid
   task acc(input w, input [7:0] a, input [31:0] d, input [3:0] be,
      output [31:0] rd);
      integer n;
      begin
         @(posedge clk);
         {avs_address, avs_writedata, avs_byteenable} <= {a, d, be};
         {avs_read, avs_write} <= {!w, w};
         n = 0;
         @(posedge clk);
         while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge clk);
            n = n + 1;
         end
         rd = avs_readdata;
         to = (avs_waitrequest !== 1'b0);
         {avs_read, avs_write} <= 2'b00;
         {avs_address, avs_writedata} <= {~a, ~d};
      end
   endtask
endmodule

// >>> sim/stored_config_diag_addr_regs_properties.sv
/* Port checker of the stored bank.
 Assumes bind to the top; fields follow a landed write two edges on. */
`timescale 1ns/1ps
module cfg_regs_checker #(parameter ALT_VARIANT = 0) (
   input wire clk, input wire rst, input wire [7:0] avs_address,
   input wire avs_read, input wire avs_write, input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable, input wire [31:0] avs_readdata,
   input wire avs_waitrequest, input wire address_strap_pin_2,
   input wire address_strap_pin_1, input wire address_strap_pin_0,
   input wire stored_diag_on_ch_eleven, input wire stored_diag_on_ch_ten,
   input wire stored_diag_on_ch_nine, input wire stored_diag_on_ch_eight,
   input wire stored_regulator_voltage_sel,
   input wire stored_exponential_dimming_on,
   input wire [3:0] stored_bus_address, input wire address_source_select,
   input wire [3:0] active_bus_address);
   // Gathered fields and the edge where a low-lane write lands
   wire [3:0] dg = {stored_diag_on_ch_eleven, stored_diag_on_ch_ten,
      stored_diag_on_ch_nine, stored_diag_on_ch_eight};
   wire [2:0] sp = {address_strap_pin_2, address_strap_pin_1,
      address_strap_pin_0};
   wire land = avs_write && !avs_waitrequest && avs_byteenable[0];
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence c6_land; land && avs_address == 8'hc6; endsequence
   diag_write_a: assert property (land && avs_address == 8'hc5 |-> ##2
      dg == $past(avs_writedata[3:0], 2)) else $error("diag write lost");
   volt_write_a: assert property (c6_land |-> ##2
      stored_regulator_voltage_sel == $past(avs_writedata[6], 2))
      else $error("voltage select lost");
   dim_write_a: assert property (c6_land |-> ##2
      stored_exponential_dimming_on == $past(avs_writedata[4], 2))
      else $error("dimming enable lost");
   addr_write_a: assert property (c6_land |-> ##2
      stored_bus_address == $past(avs_writedata[3:0], 2))
      else $error("stored address lost");
   reset_value_a: assert property ($fell(rst) |-> dg == 4'hf &&
      stored_bus_address == (ALT_VARIANT ? 4'h8 : 4'h0))
      else $error("bad reset value");
   addr_source_a: assert property (!$past(rst) && $stable(sp) |->
      active_bus_address == (address_source_select ? stored_bus_address
      : {1'b0, sp})) else $error("wrong active address");
   reserved_zero_a: assert property (avs_read && !avs_waitrequest |->
      avs_readdata[31:8] == 24'h0 && (avs_address != 8'hc5 ||
      avs_readdata[7:4] == 4'h0) && (avs_address != 8'hc6 ||
      !avs_readdata[7] && !avs_readdata[5])) else $error("reserved set");
endmodule
bind stored_config_diag_addr_regs cfg_regs_checker #(.ALT_VARIANT(ALT_VARIANT))
   cfg_regs_checker_inst (.*);

// >>> sim/stored_config_diag_addr_regs_test.sv
/* Bench: table of bus cycles, then address source and a mid-run reset.
 Assumes the host model owns the bus lines. */
`timescale 1ns/1ps
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin bad_count++; \
   $display("mismatch %0t %h %h", $time, g, x); end end
module stored_config_diag_addr_regs_test;
   reg clk = 1'b0, rst = 1'b1;
   reg address_strap_pin_2 = 1'b1, address_strap_pin_1 = 1'b1;
   reg address_strap_pin_0 = 1'b0;
   wire [7:0] avs_address;
   wire avs_read, avs_write, avs_waitrequest, address_source_select;
   wire [31:0] avs_writedata, avs_readdata;
   wire [3:0] avs_byteenable, stored_bus_address, active_bus_address;
   wire stored_diag_on_ch_eleven, stored_diag_on_ch_ten;
   wire stored_diag_on_ch_nine, stored_diag_on_ch_eight;
   wire stored_regulator_voltage_sel, stored_exponential_dimming_on;
   reg [31:0] got;
   reg [3:0] w, b;
   reg [7:0] ad, d, e;
   integer bad_count = 0, compares = 0, i;
   // Rows: write, offset, data, lane 0, read-back
   reg [31:0] rows [0:6] = '{32'h0_c5_00_1_0f, 32'h0_c6_00_1_00,
      32'h1_c5_a5_1_05, 32'h1_c5_0a_0_05, 32'h1_c6_ff_1_5f,
      32'h1_c6_45_1_45, 32'h1_40_ff_1_00};
   stored_config_diag_addr_regs stored_config_diag_addr_regs_inst (.*);
   host_master host_master_inst (.*);
   always #25 clk = ~clk;
   task print_verdict;
      begin
         $display("compares %0d bad_count %0d", compares, bad_count);
         if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // One bus cycle; a hung wait ends the run
   task bus(input w1, input [7:0] a1, input [7:0] d1, input b1);
      begin
         host_master_inst.acc(w1, a1, {24'h0, d1}, {3'h0, b1}, got);
         if (host_master_inst.to) begin
            bad_count++;
            print_verdict;
         end
      end
   endtask
   // Table first, then strap or stored address and a second reset
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 7; i++) begin
         {w, ad, d, b, e} = rows[i];
         if (w[0]) bus(1'b1, ad, d, b[0]);
         bus(1'b0, ad, 8'h00, 1'b1);
         `CHK(got, {24'h0, e})
      end
      bus(1'b1, 8'hc7, 8'hff, 1'b1);
      bus(1'b0, 8'hc7, 8'h00, 1'b1);
      `CHK(got, 32'h08)
      `CHK(active_bus_address, 4'h5)
      `CHK({stored_regulator_voltage_sel, stored_exponential_dimming_on}, 2'h2)
      `CHK(stored_bus_address, 4'h5)
      `CHK({stored_diag_on_ch_eleven, stored_diag_on_ch_ten, stored_diag_on_ch_nine, stored_diag_on_ch_eight}, 4'h5)
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 8'hc5, 8'h00, 1'b1);
      `CHK(got, 32'h0f)
      `CHK(active_bus_address, 4'h6)
      `CHK(stored_bus_address, 4'h0)
      print_verdict;
   end
endmodule
